// [common/reload_timer_pkg.sv]
// Register map, field positions and constants for the reload timer channel
package reload_timer_pkg;
	// Register offsets on the plain register port (byte addresses)
	localparam logic [7:0] IOC_ADDR_CH0 = 8'h81;
	localparam logic [7:0] IOC_ADDR_CH1 = 8'h89;
	localparam logic [7:0] MODE_ADDR_CH0 = 8'h82;
	localparam logic [7:0] MODE_ADDR_CH1 = 8'h8a;
	localparam logic [7:0] GATE_ADDR_CH0 = 8'h83;
	localparam logic [7:0] GATE_ADDR_CH1 = 8'h8b;
	localparam logic [7:0] CNT_ADDR_CH0 = 8'h84;
	localparam logic [7:0] CNT_ADDR_CH1 = 8'h8c;
	localparam logic [7:0] CTRL_ADDR_CH0 = 8'h80;
	localparam logic [7:0] CTRL_ADDR_CH1 = 8'h88;

	// Pin I/O control fields
	localparam int IOC_POL = 0;
	localparam int IOC_OUTSEL = 1;
	localparam int IOC_FLT_LO = 4;
	localparam int IOC_GATE_LO = 6;
	localparam logic [7:0] IOC_WMASK = 8'hf7;
	localparam logic [7:0] IOC_RESET = 8'h00;

	// Mode register fields
	localparam int MODE_OP_LO = 0;
	localparam int MODE_DUAL = 3;
	localparam int MODE_CLK_LO = 4;
	localparam logic [7:0] MODE_RESET = 8'h00;

	// Gate source register fields
	localparam int GATE_SEL_LO = 0;
	localparam int GATE_INV = 2;
	localparam logic [7:0] GATE_WMASK = 8'h07;

	// Control register fields
	localparam int CTRL_START = 0;
	localparam int CTRL_STOP = 1;

	localparam logic [15:0] CNT_ALL_ONES = 16'hffff;
	localparam logic [15:0] CNT_ZERO = 16'h0000;
	localparam logic [1:0] FILTER_LEN = 2'h3;

	typedef enum logic [2:0] {
		OP_TIMER = 3'h0,
		OP_PULSE = 3'h1,
		OP_EVENT = 3'h2
	} op_mode_e;

	typedef enum logic [1:0] {
		FLT_NONE = 2'h0,
		FLT_F1 = 2'h1,
		FLT_F8 = 2'h2,
		FLT_F32 = 2'h3
	} filter_e;

	typedef enum logic [1:0] {
		GATE_ALWAYS = 2'h0,
		GATE_IRQ2 = 2'h1,
		GATE_CMP = 2'h2,
		GATE_COMP_TIMER = 2'h3
	} gate_e;

	// Count source select codes
	localparam logic [2:0] CLK_F1 = 3'h0;
	localparam logic [2:0] CLK_F8 = 3'h1;
	localparam logic [2:0] CLK_OSC = 3'h2;
	localparam logic [2:0] CLK_F2 = 3'h3;
	localparam logic [2:0] CLK_SUB32 = 3'h4;
	localparam logic [2:0] CLK_SUB = 3'h6;
	localparam logic [2:0] CLK_CHAIN = 3'h7;

	// Internal clock enables that feed the channel
	typedef struct packed {
		logic f2;
		logic f8;
		logic f32;
		logic osc;
		logic sub32;
		logic sub;
		logic chain;
	} tick_s;

	// Gate sources from neighbouring logic
	typedef struct packed {
		logic irq_two;
		logic irq_two_pol;
		logic comp_timer;
		logic [3:0] compare;
	} gate_in_s;
endpackage

// [hw/reload_timer.sv]
// One 16-bit reload timer channel: pulse output and event counter modes
// What this block does
// [RULE_01] Pulse mode toggles pin on every underflow
// [RULE_02] Pulse mode counts selected internal clock source
// [RULE_03] Decrement; reload on underflow, keep counting
// [RULE_04] Value m gives one underflow per m+1
// [RULE_05] Writing start bit one begins counting
// [RULE_06] Start zero or force stop halts counting
// [RULE_07] Underflow raises channel interrupt request
// [RULE_08] Counter read returns present count
// [RULE_09] Counter write loads reload and counter
// [RULE_10] Polarity bit picks pulse starting level
// [RULE_11] Mode write forces output to start level
// [RULE_12] Output select bit returns pin to port
// [RULE_13] Software keeps filter off in pulse mode
// [RULE_14] Event mode counts rising or falling edges
// [RULE_15] Software keeps polarity fixed while counting
// [RULE_16] Filter field selects none, f1, f8, f32
// [RULE_17] Filter accepts level after three equal samples
// [RULE_18] Gate field selects when events count
// [RULE_19] Irq-two gate level follows its polarity
// [RULE_20] Companion gate counts on its high level
// [RULE_21] Compare gate: source select plus invert
// [RULE_22] Reserved bit two writes, bit three reads zero
// [RULE_23] Mode field: 001 pulse, 010 event
// [RULE_24] Both edges only in event counter mode
// [RULE_25] Force stop sets counter to all ones
// [RULE_26] Underflow is a count event at zero
// [RULE_27] Pin input synchronised before any use
`timescale 1ns/100ps
module reload_timer #(
	parameter bit CHANNEL = 1'b0
) (
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	input wire logic [7:0] addr_i,
	input wire logic [15:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [15:0] rdata_o,
	input wire reload_timer_pkg::tick_s tick_i,
	input wire reload_timer_pkg::gate_in_s gate_i,
	input wire logic timer_io_pin_i,
	output logic timer_io_pin_o,
	output logic timer_io_pin_oe_o,
	output logic irq_o,
	output logic underflow_o
);
	localparam logic [7:0] IOC_A = CHANNEL ? reload_timer_pkg::IOC_ADDR_CH1
		: reload_timer_pkg::IOC_ADDR_CH0;
	localparam logic [7:0] MODE_A = CHANNEL ?
		reload_timer_pkg::MODE_ADDR_CH1 : reload_timer_pkg::MODE_ADDR_CH0;
	localparam logic [7:0] GATE_A = CHANNEL ?
		reload_timer_pkg::GATE_ADDR_CH1 : reload_timer_pkg::GATE_ADDR_CH0;
	localparam logic [7:0] CNT_A = CHANNEL ? reload_timer_pkg::CNT_ADDR_CH1
		: reload_timer_pkg::CNT_ADDR_CH0;
	localparam logic [7:0] CTRL_A = CHANNEL ?
		reload_timer_pkg::CTRL_ADDR_CH1 : reload_timer_pkg::CTRL_ADDR_CH0;

	logic [7:0] io_ctrl;
	logic [7:0] mode;
	logic [2:0] gate_src;
	logic running;
	logic [15:0] counter;
	logic [15:0] reload;
	logic pulse_level;
	logic pin_meta;
	logic pin_sync;
	logic [1:0] flt_cnt;
	logic flt_level;
	logic flt_prev;
	logic src_tick;
	logic flt_tick;
	logic gate_open;
	logic edge_hit;
	logic count_evt;
	logic underflow;
	logic [3:0] cmp_pick;
	logic [2:0] op_field;
	logic pulse_mode;
	logic event_mode;
	logic wr_ioc;
	logic wr_mode;
	logic wr_gate;
	logic wr_cnt;
	logic wr_ctrl;

	assign wr_ioc = wr_i && (addr_i == IOC_A);
	assign wr_mode = wr_i && (addr_i == MODE_A);
	assign wr_gate = wr_i && (addr_i == GATE_A);
	assign wr_cnt = wr_i && (addr_i == CNT_A);
	assign wr_ctrl = wr_i && (addr_i == CTRL_A);

	// Mode decode; other modes simply never count here
	assign op_field = mode[reload_timer_pkg::MODE_OP_LO +: 3];
	assign pulse_mode = (op_field == reload_timer_pkg::OP_PULSE); // see [RULE_23]
	assign event_mode = (op_field == reload_timer_pkg::OP_EVENT); // see [RULE_23]

	// Pin I/O control register; bit 3 never stores so it reads zero
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			io_ctrl <= reload_timer_pkg::IOC_RESET;
		end else if (wr_ioc) begin
			io_ctrl <= wdata_i[7:0] & reload_timer_pkg::IOC_WMASK; // see [RULE_22]
		end
	end

	// Mode register
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			mode <= reload_timer_pkg::MODE_RESET;
		end else if (wr_mode) begin
			mode <= wdata_i[7:0];
		end
	end

	// Gate source select register
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			gate_src <= '0;
		end else if (wr_gate) begin
			gate_src <= wdata_i[2:0];
		end
	end

	// Run flag; force stop wins over a start written in the same cycle
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			running <= 1'b0;
		end else if (wr_ctrl) begin
			if (wdata_i[reload_timer_pkg::CTRL_STOP]) begin
				running <= 1'b0; // see [RULE_06]
			end else begin
				running <= wdata_i[reload_timer_pkg::CTRL_START]; // see [RULE_05]
			end
		end
	end

	// Internal count source selection; chaining is channel one only
	always_comb begin
		unique case (mode[reload_timer_pkg::MODE_CLK_LO +: 3])
			reload_timer_pkg::CLK_F1: src_tick = 1'b1;
			reload_timer_pkg::CLK_F2: src_tick = tick_i.f2;
			reload_timer_pkg::CLK_F8: src_tick = tick_i.f8;
			reload_timer_pkg::CLK_OSC: src_tick = tick_i.osc;
			reload_timer_pkg::CLK_SUB32: src_tick = tick_i.sub32;
			reload_timer_pkg::CLK_SUB: src_tick = tick_i.sub;
			reload_timer_pkg::CLK_CHAIN: src_tick = CHANNEL && tick_i.chain;
			default: src_tick = 1'b0;
		endcase
	end // see [RULE_02]

	// Pin synchroniser: the first stage feeds only the second
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pin_meta <= 1'b0;
			pin_sync <= 1'b0;
		end else begin
			pin_meta <= timer_io_pin_i;
			pin_sync <= pin_meta; // see [RULE_27]
		end
	end

	// Filter sampling strobe from the chosen sampling clock
	always_comb begin
		unique case (reload_timer_pkg::filter_e'(
			io_ctrl[reload_timer_pkg::IOC_FLT_LO +: 2]))
			reload_timer_pkg::FLT_F1: flt_tick = 1'b1;
			reload_timer_pkg::FLT_F8: flt_tick = tick_i.f8;
			reload_timer_pkg::FLT_F32: flt_tick = tick_i.f32;
			default: flt_tick = 1'b0;
		endcase
	end // see [RULE_16]

	// Digital filter: level accepted after three equal samples in a row
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			flt_cnt <= '0;
			flt_level <= 1'b0;
		end else if (io_ctrl[reload_timer_pkg::IOC_FLT_LO +: 2] ==
			reload_timer_pkg::FLT_NONE) begin
			flt_cnt <= '0;
			flt_level <= pin_sync; // see [RULE_16]
		end else if (flt_tick) begin
			if (pin_sync == flt_level) begin
				flt_cnt <= '0;
			end else if (flt_cnt == reload_timer_pkg::FILTER_LEN - 2'h1) begin
				flt_cnt <= '0;
				flt_level <= pin_sync; // see [RULE_17]
			end else begin
				flt_cnt <= flt_cnt + 2'h1;
			end
		end
	end

	// Previous filtered level for edge detection
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			flt_prev <= 1'b0;
		end else begin
			flt_prev <= flt_level;
		end
	end

	// Edge select: both edges honoured only in event mode
	always_comb begin
		if (mode[reload_timer_pkg::MODE_DUAL]) begin
			edge_hit = flt_level ^ flt_prev; // see [RULE_24]
		end else if (io_ctrl[reload_timer_pkg::IOC_POL]) begin
			edge_hit = flt_prev && !flt_level; // see [RULE_14]
		end else begin
			edge_hit = !flt_prev && flt_level; // see [RULE_14]
		end
	end

	// Compare output pick: 00 d, 01 c, 10 b, 11 a
	assign cmp_pick = gate_i.compare;

	// Event gate selection
	always_comb begin
		unique case (reload_timer_pkg::gate_e'(
			io_ctrl[reload_timer_pkg::IOC_GATE_LO +: 2]))
			reload_timer_pkg::GATE_IRQ2:
				gate_open = gate_i.irq_two ^ gate_i.irq_two_pol; // see [RULE_19]
			reload_timer_pkg::GATE_CMP:
				gate_open = cmp_pick[gate_src[reload_timer_pkg::GATE_SEL_LO +: 2]]
					^ !gate_src[reload_timer_pkg::GATE_INV]; // see [RULE_21]
			reload_timer_pkg::GATE_COMP_TIMER:
				gate_open = gate_i.comp_timer; // see [RULE_20]
			default: gate_open = 1'b1;
		endcase
	end // see [RULE_18]

	// Count event from the source that the mode selects
	always_comb begin
		if (!running) begin
			count_evt = 1'b0;
		end else if (pulse_mode) begin
			count_evt = src_tick; // see [RULE_01]
		end else if (event_mode) begin
			count_evt = edge_hit && gate_open; // see [RULE_18]
		end else begin
			count_evt = 1'b0;
		end
	end

	assign underflow = count_evt && (counter == reload_timer_pkg::CNT_ZERO); // see [RULE_26]

	// Reload register follows every counter write
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			reload <= reload_timer_pkg::CNT_ALL_ONES;
		end else if (wr_cnt) begin
			reload <= wdata_i; // see [RULE_09]
		end else if (wr_ctrl && wdata_i[reload_timer_pkg::CTRL_STOP]) begin
			reload <= reload_timer_pkg::CNT_ALL_ONES; // see [RULE_25]
		end
	end

	// Down counter; software write wins over a count in the same cycle
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			counter <= reload_timer_pkg::CNT_ALL_ONES;
		end else if (wr_ctrl && wdata_i[reload_timer_pkg::CTRL_STOP]) begin
			counter <= reload_timer_pkg::CNT_ALL_ONES; // see [RULE_25]
		end else if (wr_cnt) begin
			counter <= wdata_i; // see [RULE_09]
		end else if (underflow) begin
			counter <= reload; // see [RULE_03] [RULE_04]
		end else if (count_evt) begin
			counter <= counter - 16'h0001; // see [RULE_03]
		end
	end

	// Pulse level: reset or mode write restores the start level
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pulse_level <= 1'b1;
		end else if (wr_mode) begin
			pulse_level <= !io_ctrl[reload_timer_pkg::IOC_POL]; // see [RULE_11] [RULE_10]
		end else if (underflow && pulse_mode) begin
			pulse_level <= !pulse_level; // see [RULE_01]
		end
	end

	// Pin drivers; the output select bit hands the pin back to the port
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			timer_io_pin_o <= 1'b0;
			timer_io_pin_oe_o <= 1'b0;
		end else begin
			timer_io_pin_o <= pulse_level;
			timer_io_pin_oe_o <= pulse_mode &&
				!io_ctrl[reload_timer_pkg::IOC_OUTSEL]; // see [RULE_12]
		end
	end

	// Interrupt request and chain pulse, one cycle each
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			irq_o <= 1'b0;
			underflow_o <= 1'b0;
		end else begin
			irq_o <= underflow; // see [RULE_07]
			underflow_o <= underflow;
		end
	end

	// Read data in the cycle after the read strobe; unmapped reads zero
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rdata_o <= '0;
		end else if (!rd_i) begin
			rdata_o <= '0;
		end else if (addr_i == CNT_A) begin
			rdata_o <= counter; // see [RULE_08]
		end else if (addr_i == IOC_A) begin
			rdata_o <= {8'h00, io_ctrl}; // see [RULE_22]
		end else if (addr_i == MODE_A) begin
			rdata_o <= {8'h00, mode};
		end else if (addr_i == GATE_A) begin
			rdata_o <= {13'h0000, gate_src};
		end else if (addr_i == CTRL_A) begin
			rdata_o <= {15'h0000, running};
		end else begin
			rdata_o <= '0;
		end
	end
endmodule

// [tb/pin_partner.sv]
// Pin partner: event source into the pin and a load counting pulse edges
`timescale 1ns/100ps
module pin_partner (
	input wire logic ref_clk_i,
	input wire logic pin_o_i,
	input wire logic pin_oe_i,
	input wire logic src_en_i,
	input wire logic src_lvl_i,
	output logic pin_i_o,
	output int toggles_o
);
	logic last = 1'b1;
	// Device wins while driving; a released line takes the source level, or the pull-up when the source is off
	assign pin_i_o = pin_oe_i ? pin_o_i : (src_en_i ? src_lvl_i : 1'b1);
	// Load counts level changes only while the device drives the line
	initial toggles_o = 0;
	always @(posedge ref_clk_i) begin
		if (pin_oe_i && pin_o_i !== last)
			toggles_o <= toggles_o + 1;
		last <= pin_o_i;
	end
endmodule

// [tb/reload_timer_pulse_and_event_modes_bench.sv]
// Self-checking bench for one reload timer channel
`timescale 1ns/100ps
module reload_timer_pulse_and_event_modes_bench;
	localparam logic [7:0] IOC = reload_timer_pkg::IOC_ADDR_CH0;
	localparam logic [7:0] MODE = reload_timer_pkg::MODE_ADDR_CH0;
	localparam logic [7:0] GATE = reload_timer_pkg::GATE_ADDR_CH0;
	localparam logic [7:0] CNT = reload_timer_pkg::CNT_ADDR_CH0;
	localparam logic [7:0] CTRL = reload_timer_pkg::CTRL_ADDR_CH0;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [15:0] wdata = 16'h0000;
	logic wr_s = 1'b0;
	logic rd_s = 1'b0;
	logic src_lvl = 1'b0;
	reload_timer_pkg::tick_s tick = '0;
	reload_timer_pkg::gate_in_s gate = '0;
	logic [15:0] rdata;
	logic pin_o, pin_oe, pin_i, irq, en, irq_edge_polarity, hi, inv;
	logic [1:0] g, sel;
	logic [3:0] cmp;
	logic [2:0] src[6] = '{3'h0, 3'h3, 3'h1, 3'h2, 3'h4, 3'h6};
	int per[6] = '{1, 2, 8, 3, 7, 5};
	int fp[4] = '{0, 1, 8, 32};
	int toggles, m, n, e, t0;
	int cyc = 0;
	int fail_count = 0;
	int checks_done = 0;
	int irq_q[$];

	initial forever #50 clk = ~clk;

	reload_timer #(.CHANNEL(1'b0)) DUT (.ref_clk_i(clk), .rst_n_i(rst_n),
		.addr_i(addr), .wdata_i(wdata), .wr_i(wr_s), .rd_i(rd_s),
		.rdata_o(rdata), .tick_i(tick), .gate_i(gate),
		.timer_io_pin_i(pin_i), .timer_io_pin_o(pin_o),
		.timer_io_pin_oe_o(pin_oe), .irq_o(irq), .underflow_o());
	pin_partner peer (.ref_clk_i(clk), .pin_o_i(pin_o), .pin_oe_i(pin_oe),
		.src_en_i(1'b1), .src_lvl_i(src_lvl), .pin_i_o(pin_i),
		.toggles_o(toggles));

	// Clock enables at fixed ratios; underflow times feed the period model
	always @(posedge clk) begin
		cyc <= cyc + 1;
		tick <= '{cyc % 2 == 0, cyc % 8 == 0, cyc % 32 == 0, cyc % 3 == 0,
			cyc % 7 == 0, cyc % 5 == 0, cyc % 4 == 0};
		if (irq === 1'b1)
			irq_q.push_back(cyc);
		if (cyc == 20000) begin
			fail_count++;
			complete_run();
		end
	end

	// Strobes stay up between back-to-back cycles; idle drops them
	task automatic idle(input int k);
		wr_s <= 1'b0;
		rd_s <= 1'b0;
		repeat (k) @(posedge clk);
	endtask
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [15:0] d);
		wr_s <= w;
		rd_s <= !w;
		addr <= a;
		wdata <= d;
		@(posedge clk);
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_num(input int got, input int exp);
		checks_done++;
		if (got != exp) begin
			fail_count++;
			$display("[ERR] %0t count %0d expected %0d", $time, got, exp);
		end
	endtask
	// Read data stand only in the cycle after the strobe, so look inside it
	task automatic rdc(input logic [7:0] a, input logic [15:0] exp);
		bus(1'b0, a, 16'h0000);
		wr_s <= 1'b0;
		rd_s <= 1'b0;
		#1;
		chk(rdata, exp);
		@(posedge clk);
	endtask
	task automatic pin(input logic v, input int k);
		src_lvl <= v;
		repeat (k) @(posedge clk);
	endtask
	task automatic complete_run;
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	initial begin
		void'($urandom(32'h85bce598));
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		rdc(IOC, 16'h0000);
		rdc(MODE, 16'h0000);
		rdc(CNT, 16'hffff);
		bus(1'b1, IOC, 16'h00ff);
		rdc(IOC, 16'h00f7);
		rdc(8'h90, 16'h0000);
		// Pulse mode on every internal source except chaining, start level alternating
		for (int k = 0; k < 6; k++) begin
			m = $urandom_range(4, 1);
			bus(1'b1, IOC, {15'h0000, k[0]});
			bus(1'b1, MODE, {9'h000, src[k], 4'h1});
			bus(1'b1, CNT, m[15:0]);
			idle(3);
			chk(16'(pin_i), 16'(!k[0]));
			irq_q.delete();
			t0 = toggles;
			bus(1'b1, CTRL, 16'h0001);
			idle((m + 1) * per[k] * 3 + 2 * per[k] + 4);
			bus(1'b1, CTRL, 16'h0000);
			idle(4);
			e = irq_q[2] - irq_q[1];
			chk_num(e, (m + 1) * per[k]);
			chk_num(toggles - t0, irq_q.size());
		end
		bus(1'b1, IOC, 16'h0002);
		idle(3);
		chk(16'(pin_oe), 16'h0000);
		bus(1'b1, CTRL, 16'h0001);
		bus(1'b1, CTRL, 16'h0002);
		rdc(CNT, 16'hffff);
		// Event mode: each gate choice, enabled and blocked except the always gate, rising and falling edge
		bus(1'b1, MODE, 16'h0002);
		for (int k = 0; k < 16; k++) begin
			g = k[3:2];
			en = k[1];
			irq_edge_polarity = k[0];
			sel = 2'($urandom_range(3, 0));
			inv = 1'($urandom_range(1, 0));
			hi = 1'($urandom_range(1, 0));
			cmp = 4'($urandom);
			cmp[sel] = !(en ^ inv);
			m = $urandom_range(20, 8);
			n = $urandom_range(4, 1);
			bus(1'b1, CTRL, 16'h0000);
			src_lvl <= 1'b0;
			gate <= '{en ^ hi, hi, en, cmp};
			bus(1'b1, GATE, {13'h0000, inv, sel});
			bus(1'b1, IOC, {8'h00, g, 5'h00, irq_edge_polarity});
			bus(1'b1, CNT, m[15:0]);
			idle(6);
			bus(1'b1, CTRL, 16'h0001);
			idle(1);
			repeat (n) begin
				pin(1'b1, $urandom_range(9, 5));
				pin(1'b0, $urandom_range(9, 5));
			end
			pin(1'b1, 8);
			e = (g == 2'h0 || en) ? n + (irq_edge_polarity == 1'b0) : 0;
			rdc(CNT, 16'(m - e));
			rdc(CNT, 16'(m - e));
		end
		// Both edges in event mode: rise, fall, rise counts three
		bus(1'b1, CTRL, 16'h0000);
		src_lvl <= 1'b0;
		bus(1'b1, MODE, 16'h000a);
		bus(1'b1, IOC, 16'h0000);
		bus(1'b1, CNT, 16'h000a);
		idle(6);
		bus(1'b1, CTRL, 16'h0001);
		idle(1);
		pin(1'b1, 6);
		pin(1'b0, 6);
		pin(1'b1, 8);
		rdc(CNT, 16'h0007);
		bus(1'b1, MODE, 16'h0002);
		// Filter: a glitch of at most two samples is dropped, a held level is taken
		for (int k = 1; k < 4; k++) begin
			bus(1'b1, CTRL, 16'h0000);
			src_lvl <= 1'b0;
			bus(1'b1, IOC, {10'h000, k[1:0], 4'h0});
			bus(1'b1, CNT, 16'h0009);
			idle(4 * fp[k] + 8);
			bus(1'b1, CTRL, 16'h0001);
			idle(1);
			pin(1'b1, 2 * fp[k] - 1);
			pin(1'b0, 4 * fp[k] + 8);
			pin(1'b1, 4 * fp[k] + 8);
			rdc(CNT, 16'h0008);
		end
		bus(1'b1, CNT, 16'h0005);
		rdc(CNT, 16'h0005);
		complete_run();
	end
endmodule

// [tb/reload_timer_sva.sv]
// Port checker for one reload timer channel
`timescale 1ns/100ps
module reload_timer_sva (
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	input wire logic [7:0] addr_i,
	input wire logic [15:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [15:0] rdata_o,
	input wire logic timer_io_pin_o,
	input wire logic timer_io_pin_oe_o,
	input wire logic irq_o,
	input wire logic underflow_o
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!rst_n_i);
	logic ioc_w, ctl_w, mode_w;
	// Software writes that the pin and counter react to
	assign ioc_w = wr_i && addr_i == reload_timer_pkg::IOC_ADDR_CH0;
	assign ctl_w = wr_i && addr_i == reload_timer_pkg::CTRL_ADDR_CH0;
	assign mode_w = wr_i && addr_i == reload_timer_pkg::MODE_ADDR_CH0;

	a_irq_uf_same: assert property (irq_o == underflow_o)
		else $error("irq and underflow pulses differ");
	a_rdata_idle: assert property (!rd_i |=> rdata_o == 16'h0)
		else $error("read data outside its slot");
	a_ioc_spare: assert property (
		rd_i && addr_i == reload_timer_pkg::IOC_ADDR_CH0 |=> !rdata_o[3])
		else $error("unassigned control bit reads one");
	a_port_release: assert property (
		ioc_w && wdata_i[1] |-> ##2 !timer_io_pin_oe_o)
		else $error("pin still driven in port use");
	a_event_undriven: assert property (
		mode_w && wdata_i[2:0] == reload_timer_pkg::OP_EVENT
		|-> ##2 !timer_io_pin_oe_o)
		else $error("pin driven in event mode");
	// Guards keep mode writes, which force the level, out of both checks
	a_pin_toggle: assert property (
		irq_o && timer_io_pin_oe_o && !wr_i && !$past(wr_i)
		|=> timer_io_pin_o != $past(timer_io_pin_o))
		else $error("pulse level not inverted on underflow");
	a_pin_hold: assert property (
		timer_io_pin_oe_o && !irq_o && !wr_i && !$past(wr_i)
		&& !$past(wr_i, 2) |=> $stable(timer_io_pin_o))
		else $error("pulse level moved without underflow");
	a_halt_quiet: assert property (
		ctl_w && (!wdata_i[0] || wdata_i[1]) |=> ##1 !irq_o [*8])
		else $error("underflow after counting halted");
	a_stop_ones: assert property (
		ctl_w && wdata_i[1] ##1 rd_i
		&& addr_i == reload_timer_pkg::CNT_ADDR_CH0
		|=> rdata_o == reload_timer_pkg::CNT_ALL_ONES)
		else $error("counter not all ones after force stop");
endmodule

bind reload_timer reload_timer_sva chk (.ref_clk_i(ref_clk_i),
	.rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
	.rd_i(rd_i), .rdata_o(rdata_o), .timer_io_pin_o(timer_io_pin_o),
	.timer_io_pin_oe_o(timer_io_pin_oe_o), .irq_o(irq_o),
	.underflow_o(underflow_o));
